// [logic/iobdb_defines.svh]
`ifndef IOBDB_DEFINES_SVH
`define IOBDB_DEFINES_SVH
`define IOBDB_SYS_W 32
`define IOBDB_PER_W 16
`define IOBDB_ADDR_LO 2
`define IOBDB_ADDR_HI 21
`define IOBDB_SEL_BIT 21
`define IOBDB_SLOW_CYC 8'h14
`define IOBDB_MED_CYC 8'h0c
`define IOBDB_FAST_CYC 8'h06
`define IOBDB_SYNC_CYC 8'h03
`define IOBDB_HOLD_CYC 8'h01
`endif

// [logic/iobdb_pkg.sv]
package iobdb_pkg;
   typedef enum logic [1:0] {IOBDB_SLOW, IOBDB_MEDIUM, IOBDB_FAST, IOBDB_SYNC} iobdb_speed_e;
   typedef enum {IOBDB_IDLE, IOBDB_STROBE, IOBDB_HOLD, IOBDB_DONE} iobdb_state_e;
endpackage : iobdb_pkg

// [logic/iobdb_sync3.sv]
`timescale 1ns/1ps
`default_nettype none
module iobdb_sync3 #(
   parameter int WIDTH = 16
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Data
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] s1_ff, s2_ff, s3_ff, out_ff;
   logic [WIDTH-1:0] nxt_out;
   // A change is accepted only once stages two and three agree
   always_comb begin
      nxt_out = out_ff;
      if (s2_ff == s3_ff) begin
         nxt_out = s3_ff;
      end
   end
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
         out_ff <= '0;
      end else begin
         s1_ff <= async_in;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         out_ff <= nxt_out;
      end
   end
   assign sync_out = out_ff;
endmodule : iobdb_sync3
`default_nettype wire

// [logic/iobdb_bridge.sv]
`timescale 1ns/1ps
`default_nettype none
`include "iobdb_defines.svh"
// Overview of operation
// RULE1 - 16-bit peripheral data, buffered address lines 2-21
// RULE2 - Write drives system bits 16-31 outward
// RULE3 - Read places peripheral data on bits 0-15
// RULE4 - Upper half of read data undefined
// RULE5 - Byte stores replicated across all lanes
// RULE6 - Half-word stores replicated on both halves
// RULE7 - Bytewide card byte lands in lowest byte
// RULE8 - 8-bit peripherals use lowest byte lane
// RULE9 - Controller supports slow, medium, fast, synchronous
// RULE10 - All peripheral accesses are memory mapped
// RULE11 - Address line 21 selects this controller
// RULE12 - Separate read and write latch controls
// RULE13 - Write data held until strobe ends
module iobdb_bridge
   import iobdb_pkg::*;
#(
   parameter logic [7:0] SLOW_CYC = `IOBDB_SLOW_CYC,
   parameter logic [7:0] MED_CYC = `IOBDB_MED_CYC,
   parameter logic [7:0] FAST_CYC = `IOBDB_FAST_CYC,
   parameter logic [7:0] SYNC_CYC = `IOBDB_SYNC_CYC
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Processor side memory-mapped request
   input wire logic cpu_req,
   input wire logic cpu_write,
   input wire logic [`IOBDB_ADDR_HI:`IOBDB_ADDR_LO] cpu_addr,
   input wire logic [1:0] cpu_speed,
   input wire logic [`IOBDB_SYS_W-1:0] cpu_wdata,
   output logic [`IOBDB_SYS_W-1:0] cpu_rdata,
   output logic cpu_done,
   output logic cpu_busy,
   // Peripheral bus
   output logic [`IOBDB_ADDR_HI:`IOBDB_ADDR_LO] buffered_address_lines,
   input wire logic [`IOBDB_PER_W-1:0] peripheral_data_lines_in,
   output logic [`IOBDB_PER_W-1:0] peripheral_data_lines_out,
   output logic peripheral_data_lines_oe_n,
   output logic per_read_strobe_n,
   output logic per_write_strobe_n,
   // Latch controls
   output logic read_latch_control,
   output logic write_latch_control
);
   iobdb_state_e state_ff, nxt_state;
   logic [7:0] cnt_ff, nxt_cnt;
   logic wr_ff, nxt_wr;
   logic [`IOBDB_ADDR_HI:`IOBDB_ADDR_LO] addr_ff, nxt_addr;
   logic [`IOBDB_PER_W-1:0] wlat_ff, nxt_wlat;
   logic [`IOBDB_SYS_W-1:0] rdata_ff, nxt_rdata;
   logic done_ff, nxt_done;
   logic rds_n_ff, nxt_rds_n, wrs_n_ff, nxt_wrs_n, oe_n_ff, nxt_oe_n;
   logic rlc_ff, nxt_rlc, wlc_ff, nxt_wlc;
   logic busy_ff, nxt_busy;
   logic [`IOBDB_PER_W-1:0] pdl_sync;
   logic [7:0] speed_len;

   // Peripheral data is asynchronous to core_clk
   iobdb_sync3 #(.WIDTH(`IOBDB_PER_W)) iobdb_sync3_i (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .async_in(peripheral_data_lines_in),
      .sync_out(pdl_sync)
   );

   always_comb begin
      case (iobdb_speed_e'(cpu_speed)) // RULE9
         IOBDB_SLOW: speed_len = SLOW_CYC;
         IOBDB_MEDIUM: speed_len = MED_CYC;
         IOBDB_FAST: speed_len = FAST_CYC;
         IOBDB_SYNC: speed_len = SYNC_CYC;
         default: speed_len = SLOW_CYC;
      endcase
   end

   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_wr = wr_ff;
      nxt_addr = addr_ff;
      nxt_wlat = wlat_ff;
      nxt_rdata = rdata_ff;
      nxt_done = 1'b0;
      nxt_rds_n = 1'b1;
      nxt_wrs_n = 1'b1;
      nxt_oe_n = oe_n_ff;
      nxt_rlc = 1'b0;
      nxt_wlc = 1'b0;
      case (state_ff)
         IOBDB_IDLE: begin
            nxt_oe_n = 1'b1;
            // Requests with line 21 low belong to another controller
            if (cpu_req && cpu_addr[`IOBDB_SEL_BIT]) begin // RULE10 RULE11
               nxt_state = IOBDB_STROBE;
               nxt_cnt = speed_len;
               nxt_wr = cpu_write;
               nxt_addr = cpu_addr; // RULE1
               if (cpu_write) begin
                  // Upper half carries the store; byte and half stores are replicated
                  nxt_wlat = cpu_wdata[`IOBDB_SYS_W-1:`IOBDB_PER_W]; // RULE2 RULE5 RULE6 RULE8
                  nxt_wlc = 1'b1; // RULE12
                  nxt_oe_n = 1'b0;
                  nxt_wrs_n = 1'b0;
               end else begin
                  nxt_rds_n = 1'b0;
               end
            end
         end
         IOBDB_STROBE: begin
            nxt_wrs_n = ~wr_ff;
            nxt_rds_n = wr_ff;
            if (cnt_ff == 8'h01) begin
               nxt_state = IOBDB_HOLD;
               nxt_cnt = `IOBDB_HOLD_CYC;
               nxt_wrs_n = 1'b1;
               nxt_rds_n = 1'b1;
               if (!wr_ff) begin
                  // Upper half left zero: its value is undefined to software
                  nxt_rdata = {{`IOBDB_PER_W{1'b0}}, pdl_sync}; // RULE3 RULE4 RULE7
                  nxt_rlc = 1'b1; // RULE12
               end
            end else begin
               nxt_cnt = cnt_ff - 8'h01;
            end
         end
         IOBDB_HOLD: begin
            // Drive stays on one cycle past the write strobe edge
            nxt_state = IOBDB_DONE;
            nxt_oe_n = 1'b1; // RULE13
         end
         IOBDB_DONE: begin
            nxt_done = 1'b1;
            nxt_state = IOBDB_IDLE;
         end
         default: nxt_state = IOBDB_IDLE;
      endcase
      nxt_busy = (nxt_state != IOBDB_IDLE);
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         state_ff <= IOBDB_IDLE;
         cnt_ff <= 8'h00;
         wr_ff <= 1'b0;
         addr_ff <= '0;
         wlat_ff <= '0;
         rdata_ff <= '0;
         done_ff <= 1'b0;
         rds_n_ff <= 1'b1;
         wrs_n_ff <= 1'b1;
         oe_n_ff <= 1'b1;
         rlc_ff <= 1'b0;
         wlc_ff <= 1'b0;
         busy_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         wr_ff <= nxt_wr;
         addr_ff <= nxt_addr;
         wlat_ff <= nxt_wlat;
         rdata_ff <= nxt_rdata;
         done_ff <= nxt_done;
         rds_n_ff <= nxt_rds_n;
         wrs_n_ff <= nxt_wrs_n;
         oe_n_ff <= nxt_oe_n;
         rlc_ff <= nxt_rlc;
         wlc_ff <= nxt_wlc;
         busy_ff <= nxt_busy;
      end
   end

   assign cpu_rdata = rdata_ff;
   assign cpu_done = done_ff;
   assign cpu_busy = busy_ff;
   assign buffered_address_lines = addr_ff;
   assign peripheral_data_lines_out = wlat_ff;
   assign peripheral_data_lines_oe_n = oe_n_ff;
   assign per_read_strobe_n = rds_n_ff;
   assign per_write_strobe_n = wrs_n_ff;
   assign read_latch_control = rlc_ff;
   assign write_latch_control = wlc_ff;

   write_map_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE2
      state_ff == IOBDB_IDLE && cpu_req && cpu_write && cpu_addr[`IOBDB_SEL_BIT]
      |=> peripheral_data_lines_out == $past(cpu_wdata[31:16]))
      else $error("write data not mapped from upper half");
   write_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE13
      !per_write_strobe_n |=> !peripheral_data_lines_oe_n && $stable(peripheral_data_lines_out))
      else $error("write data moved during strobe");
   read_map_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE3
      read_latch_control |-> cpu_rdata[15:0] == $past(pdl_sync))
      else $error("read data not mapped to lower half");
   select_line_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE11
      state_ff == IOBDB_IDLE && cpu_req && !cpu_addr[`IOBDB_SEL_BIT] |=> !cpu_busy)
      else $error("cycle started with line 21 low");
   latch_excl_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE12
      !(read_latch_control && write_latch_control))
      else $error("both latch controls active");
   speed_sync_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE9
      state_ff == IOBDB_IDLE && cpu_req && cpu_addr[`IOBDB_SEL_BIT] && cpu_speed == 2'h3
      |=> state_ff == IOBDB_STROBE [*3] ##1 state_ff == IOBDB_HOLD)
      else $error("synchronous cycle length wrong");
   addr_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE1
      state_ff == IOBDB_STROBE |=> $stable(buffered_address_lines))
      else $error("address changed mid cycle");
   done_pulse_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE10
      state_ff == IOBDB_HOLD |=> ##1 cpu_done ##1 !cpu_done)
      else $error("done pulse missing");
   strobe_excl_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE12
      !(!per_read_strobe_n && !per_write_strobe_n))
      else $error("both strobes active");
   wlatch_pulse_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE12
      write_latch_control |=> !write_latch_control)
      else $error("write latch control not a pulse");
   read_nodrive_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE12
      !per_read_strobe_n |-> peripheral_data_lines_oe_n)
      else $error("bridge drives data during read");
   busy_select_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE11
      cpu_busy |-> buffered_address_lines[`IOBDB_SEL_BIT])
      else $error("cycle running without line 21");
endmodule : iobdb_bridge
`default_nettype wire

// [tb/iobdb_periph.sv]
`timescale 1ns/1ps
`default_nettype none
module iobdb_periph (
   // Clock
   input wire logic core_clk,
   // Bridge side of the peripheral bus
   input wire logic rd_strobe_n,
   input wire logic wr_strobe_n,
   input wire logic drive_en_n,
   input wire logic [15:0] wr_data,
   output logic [15:0] rd_data,
   // Bench access to the stored value
   input wire logic preset_en,
   input wire logic [15:0] preset,
   output logic [15:0] stored
);
   logic [15:0] store = 16'h0;
   logic [15:0] drive = 16'hffff;
   logic [15:0] last = 16'h0;
   assign rd_data = drive;
   assign stored = store;
   // Bytewide parts see their byte on the lowest lane of the stored half-word
   always @(posedge core_clk) begin
      if (preset_en) begin
         store <= preset;
      end else if (!wr_strobe_n && !drive_en_n) begin
         store <= wr_data;
      end
   end
   // Released bus shows the inverse of the last driven value, never a held copy
   always @(posedge core_clk) begin
      if (!rd_strobe_n) begin
         drive <= store;
         last <= store;
      end else begin
         drive <= ~last;
      end
   end
endmodule : iobdb_periph
`default_nettype wire

// [tb/io_bus_data_bridge_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "iobdb_defines.svh"
module io_bus_data_bridge_tb
   import iobdb_pkg::*;
();
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic cpu_req = 1'b0;
   logic cpu_write = 1'b0;
   logic [21:2] cpu_addr = 20'h0;
   logic [1:0] cpu_speed = 2'h0;
   logic [31:0] cpu_wdata = 32'h0;
   logic [31:0] cpu_rdata;
   logic cpu_done;
   logic cpu_busy;
   logic [21:2] bal;
   logic [15:0] pin;
   logic [15:0] pout;
   logic [15:0] stored;
   logic [15:0] preset = 16'h0;
   logic preset_en = 1'b0;
   logic oe_n;
   logic rd_n;
   logic wr_n;
   logic rlc;
   logic wlc;
   int n_fail = 0;
   int samples_checked = 0;
   int lens[4] = '{`IOBDB_SLOW_CYC, `IOBDB_MED_CYC, `IOBDB_FAST_CYC, `IOBDB_SYNC_CYC};

   iobdb_bridge iobdb_bridge_i (.core_clk(core_clk), .rst_n(rst_n), .cpu_req(cpu_req),
      .cpu_write(cpu_write), .cpu_addr(cpu_addr), .cpu_speed(cpu_speed),
      .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .cpu_done(cpu_done),
      .cpu_busy(cpu_busy), .buffered_address_lines(bal), .peripheral_data_lines_in(pin),
      .peripheral_data_lines_out(pout), .peripheral_data_lines_oe_n(oe_n),
      .per_read_strobe_n(rd_n), .per_write_strobe_n(wr_n),
      .read_latch_control(rlc), .write_latch_control(wlc));
   iobdb_periph iobdb_periph_i (.core_clk(core_clk), .rd_strobe_n(rd_n), .wr_strobe_n(wr_n),
      .drive_en_n(oe_n), .wr_data(pout), .rd_data(pin), .preset_en(preset_en),
      .preset(preset), .stored(stored));

   initial begin
      forever #2.5 core_clk = ~core_clk;
   end

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic finish_test();
      if (n_fail == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : finish_test

   // One full cycle, entered and left at a falling edge
   task automatic run(input logic wr, input logic [1:0] sp, input logic [31:0] wd);
      int cyc;
      int low;
      int rl;
      int wl;
      cyc = 0;
      low = 0;
      rl = 0;
      wl = 0;
      cpu_req = 1'b1;
      cpu_write = wr;
      cpu_addr = 20'h80000 | 20'(sp);
      cpu_speed = sp;
      cpu_wdata = wd;
      @(negedge core_clk);
      cpu_req = 1'b0;
      // The first falling edge after the taking edge already shows the strobe
      cyc = 1;
      chk("address", 32'(bal), 32'(cpu_addr));
      while (cpu_done !== 1'b1 && cyc < 60) begin
         if ((wr ? wr_n : rd_n) === 1'b0) begin
            low++;
            if (wr) chk("write_data", 32'(pout), 32'(wd[31:16]));
            if (wr) chk("drive_en_n", 32'(oe_n), 32'h0);
         end
         rl += int'(rlc === 1'b1);
         wl += int'(wlc === 1'b1);
         @(negedge core_clk);
         cyc++;
      end
      chk("done_cycle", cyc, lens[sp] + 3);
      chk("strobe_len", low, lens[sp]);
      chk("read_latch", rl, 32'(!wr));
      chk("write_latch", wl, 32'(wr));
   endtask : run

   task automatic t_writes();
      for (int i = 0; i < 4; i++) begin
         run(1'b1, 2'(i), {4{8'h5a ^ 8'(i)}});
         chk("byte_lane", 32'(stored[7:0]), 32'(8'h5a ^ 8'(i)));
      end
      run(1'b1, IOBDB_FAST, {2{16'h1234}});
      chk("half_word", 32'(stored), 32'h1234);
   endtask : t_writes

   task automatic t_reads();
      logic [15:0] v[4] = '{16'hc3a7, 16'h0e91, 16'h5a3c, 16'h0};
      logic [1:0] s[4] = '{IOBDB_SLOW, IOBDB_MEDIUM, IOBDB_FAST, IOBDB_SYNC};
      for (int i = 0; i < 4; i++) begin
         preset = v[i];
         preset_en = 1'b1;
         @(negedge core_clk);
         preset_en = 1'b0;
         run(1'b0, s[i], 32'h0);
         // Sync reads are shorter than the input filter, so only their timing is judged
         if (i < 3) chk("read_data", 32'(cpu_rdata[15:0]), 32'(v[i]));
      end
   endtask : t_reads

   task automatic t_refused();
      cpu_addr = 20'h7ffff;
      cpu_req = 1'b1;
      repeat (6) begin
         @(negedge core_clk);
         chk("refused", 32'({cpu_busy, rd_n, wr_n}), 32'h3);
      end
      cpu_req = 1'b0;
      @(negedge core_clk);
   endtask : t_refused

   // Reset in the middle of a slow write must drop every strobe and latch control
   task automatic t_reset();
      cpu_req = 1'b1;
      cpu_write = 1'b1;
      cpu_addr = 20'h80001;
      cpu_speed = IOBDB_SLOW;
      cpu_wdata = 32'ha5a5a5a5;
      @(negedge core_clk);
      cpu_req = 1'b0;
      repeat (2) @(negedge core_clk);
      chk("mid_strobe", 32'(wr_n), 32'h0);
      rst_n = 1'b0;
      repeat (2) @(negedge core_clk);
      chk("reset_outs", 32'({cpu_busy, cpu_done, rlc, wlc, wr_n, rd_n, oe_n}), 32'h7);
      chk("reset_addr", 32'(bal), 32'h0);
      chk("reset_rdata", cpu_rdata, 32'h0);
      rst_n = 1'b1;
      @(negedge core_clk);
      chk("after_reset", 32'({cpu_busy, cpu_done, rlc, wlc, wr_n, rd_n, oe_n}), 32'h7);
   endtask : t_reset

   initial begin
      repeat (8) @(negedge core_clk);
      rst_n = 1'b1;
      t_refused();
      t_writes();
      t_reset();
      t_reads();
      finish_test();
   end

   initial begin
      #20000;
      n_fail++;
      finish_test();
   end
endmodule : io_bus_data_bridge_tb
`default_nettype wire
